// *** src/eit_defs.svh ***
// register offsets, field positions, reset values and timer limits of the irq source block
`ifndef EIT_DEFS_SVH
`define EIT_DEFS_SVH
// ---------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------
`define EIT_OFS_MAIN 12'h000
`define EIT_OFS_CTL2 12'h004
`define EIT_OFS_CTL3 12'h008
`define EIT_OFS_RCP 12'h00C
`define EIT_OFS_MASKA 12'h010
`define EIT_OFS_MASKB 12'h014
`define EIT_OFS_SNAP 12'h018
`define EIT_OFS_TMODE 12'h01C
// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define EIT_MAIN_GEN 7
`define EIT_MAIN_TOE 5
`define EIT_MAIN_E0E 4
`define EIT_MAIN_CHE 3
`define EIT_MAIN_TOF 2
`define EIT_MAIN_E0F 1
`define EIT_MAIN_CHF 0
`define EIT_CTL2_EDG0 6
`define EIT_CTL2_EDG1 5
`define EIT_CTL2_EDG2 4
`define EIT_CTL2_TOP 2
`define EIT_CTL2_CHP 0
`define EIT_CTL3_E2P 7
`define EIT_CTL3_E1P 6
`define EIT_CTL3_E2E 4
`define EIT_CTL3_E1E 3
`define EIT_CTL3_E2F 1
`define EIT_CTL3_E1F 0
`define EIT_RCP_PLE 7
`define EIT_TMODE_16 0
// ---------------------------------------------------------------
// reset values and writable masks
// ---------------------------------------------------------------
`define EIT_RST_MAIN 8'h00
`define EIT_RST_CTL2 8'h75
`define EIT_RST_CTL3 8'hC0
`define EIT_RST_RCP 8'h00
`define EIT_RST_MASK 8'h00
`define EIT_RST_TMODE 8'h00
`define EIT_WMSK_MAIN 8'hBF
`define EIT_WMSK_CTL2 8'h75
`define EIT_WMSK_CTL3 8'hDB
`define EIT_WMSK_RCP 8'h80
`define EIT_WMSK_TMODE 8'h01
// ---------------------------------------------------------------
// timer roll-over values
// ---------------------------------------------------------------
`define EIT_T8_MAX 8'hFF
`define EIT_T8_ZERO 8'h00
`define EIT_T16_MAX 16'hFFFF
`define EIT_T16_ZERO 16'h0000
`endif

// *** src/eit_pkg.sv ***
// types shared by the irq source block
package eit_pkg;
  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef logic [7:0] eit_byte_t; // one 8-bit control register
  typedef enum logic {EIT_LVL_LOW, EIT_LVL_HIGH} eit_level_t; // request level of a source
endpackage

// *** src/eit_irq_sources.sv ***
// edge, timer overflow and port-change interrupt sources with apb registers
//
// The APB register port and the placing of the registers were decided locally.
`timescale 1ns/1ns
`include "eit_defs.svh"
// Contract
// - rising or falling edge chosen per pin
// - valid edge sets the pin flag
// - cleared enable blocks that external request
// - enabled external flag wakes from sleep; here the enable must already be set at sleep entry
// - wake branches to vector when global enabled
// - ext one and two use priority bits
// - ext zero is always high priority
// - 8-bit roll-over sets timer flag
// - 16-bit roll-over sets timer flag
// - timer enable gates timer request
// - timer priority bit picks its level
// - any port change sets change flag
// - change enable gates change request
// - only masked pins take part
// - change priority bit picks its level
// - compare pins against snapshot from last read or write of it
module eit_irq_sources (
  input wire logic CLK_I,
  input wire logic RESET_N_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [11:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  input wire logic [2:0] EXT_IRQ_I,
  input wire logic [15:0] TIMER_COUNT_I,
  input wire logic [7:0] PORTA_I,
  input wire logic [7:0] PORTB_I,
  input wire logic SLEEP_I,
  output logic IRQ_HIGH_O,
  output logic IRQ_LOW_O,
  output logic WAKE_O,
  output logic VECTOR_O
);
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  eit_pkg::eit_byte_t main_q, main_d; // enables, flags, global enable
  eit_pkg::eit_byte_t ctl2_q, ctl2_d; // polarities and priorities
  eit_pkg::eit_byte_t ctl3_q, ctl3_d; // ext one/two control
  eit_pkg::eit_byte_t rcp_q, rcp_d; // priority mode bit only
  eit_pkg::eit_byte_t maska_q, maska_d; // port a change mask
  eit_pkg::eit_byte_t maskb_q, maskb_d; // port b change mask
  eit_pkg::eit_byte_t tmode_q, tmode_d; // timer width select
  logic [15:0] snap_q, snap_d; // port values at last snapshot access
  logic [2:0] ext_prev_q; // pin levels one cycle ago
  logic [15:0] tmr_prev_q; // timer count one cycle ago
  logic sleep_prev_q; // low-power request one cycle ago
  logic [2:0] en_sleep_q, en_sleep_d; // enables captured at sleep entry
  logic [31:0] prdata_q, prdata_d; // read data, built in setup
  logic slverr_q, slverr_d; // unmapped address seen in setup
  logic irq_high_q, irq_high_d; // registered high request
  logic irq_low_q, irq_low_d; // registered low request
  logic wake_q, wake_d; // registered wake
  logic vector_q, vector_d; // registered branch request
  // ---------------------------------------------------------------
  // decoded fields
  // ---------------------------------------------------------------
  logic wr_acc; // write access phase
  logic any_acc; // any access phase
  logic [2:0] ext_flag; // flags of ext zero, one, two
  logic [2:0] ext_en; // enables of ext zero, one, two
  logic [2:0] ext_pol; // polarity, one means rising
  logic [2:0] ext_edge; // qualified edge this cycle
  logic [2:0] ext_pend; // flag and enable
  logic tmr_ovf; // timer roll-over this cycle
  logic tmr_pend; // timer flag and enable
  logic chg_mis; // any masked pin differs from snapshot
  logic chg_pend; // change flag and enable
  logic ple; // two-level priority mode
  logic sleep_hold; // in low power past the entry cycle
  logic mapped; // setup address hits a register
  eit_pkg::eit_level_t lvl1, lvl2, lvlt, lvlc; // level of each prioritised source
  assign wr_acc = PSEL_I & PENABLE_I & PWRITE_I;
  assign any_acc = PSEL_I & PENABLE_I;
  assign ext_flag = {ctl3_q[`EIT_CTL3_E2F], ctl3_q[`EIT_CTL3_E1F], main_q[`EIT_MAIN_E0F]};
  assign ext_en = {ctl3_q[`EIT_CTL3_E2E], ctl3_q[`EIT_CTL3_E1E], main_q[`EIT_MAIN_E0E]};
  assign ext_pol = {ctl2_q[`EIT_CTL2_EDG2], ctl2_q[`EIT_CTL2_EDG1], ctl2_q[`EIT_CTL2_EDG0]};
  assign ple = rcp_q[`EIT_RCP_PLE];
  // ---------------------------------------------------------------
  // event detection
  // ---------------------------------------------------------------
  // edge per pin; a polarity change while the pin is steady gives no edge
  always_comb begin
    for (int k = 0; k < 3; k++) begin
      if (ext_pol[k]) begin
        ext_edge[k] = EXT_IRQ_I[k] & ~ext_prev_q[k];
      end else begin
        ext_edge[k] = ~EXT_IRQ_I[k] & ext_prev_q[k];
      end
    end
  end
  // roll-over seen from two successive counts, so a skipped count misses it
  always_comb begin
    if (tmode_q[`EIT_TMODE_16]) begin
      tmr_ovf = (tmr_prev_q == `EIT_T16_MAX) && (TIMER_COUNT_I == `EIT_T16_ZERO);
    end else begin
      tmr_ovf = (tmr_prev_q[7:0] == `EIT_T8_MAX) && (TIMER_COUNT_I[7:0] == `EIT_T8_ZERO);
    end
  end
  // mismatch keeps setting the flag until the snapshot is refreshed
  assign chg_mis = |(((PORTB_I ^ snap_q[15:8]) & maskb_q) | ((PORTA_I ^ snap_q[7:0]) & maska_q));

  // ---------------------------------------------------------------
  // registers: software writes, then hardware sets win
  // ---------------------------------------------------------------
  always_comb begin
    main_d = main_q;
    ctl2_d = ctl2_q;
    ctl3_d = ctl3_q;
    rcp_d = rcp_q;
    maska_d = maska_q;
    maskb_d = maskb_q;
    tmode_d = tmode_q;
    snap_d = snap_q;
    // write lands only in the access phase; pready is always high there
    if (wr_acc) begin
      case (PADDR_I)
        `EIT_OFS_MAIN: main_d = PWDATA_I[7:0] & `EIT_WMSK_MAIN;
        `EIT_OFS_CTL2: ctl2_d = PWDATA_I[7:0] & `EIT_WMSK_CTL2;
        `EIT_OFS_CTL3: ctl3_d = PWDATA_I[7:0] & `EIT_WMSK_CTL3;
        `EIT_OFS_RCP: rcp_d = PWDATA_I[7:0] & `EIT_WMSK_RCP;
        `EIT_OFS_MASKA: maska_d = PWDATA_I[7:0];
        `EIT_OFS_MASKB: maskb_d = PWDATA_I[7:0];
        `EIT_OFS_TMODE: tmode_d = PWDATA_I[7:0] & `EIT_WMSK_TMODE;
        default: begin
          // snapshot and unmapped addresses store no write data
        end
      endcase
    end
    // any access to the snapshot ends the mismatch; a read latches what it returned, a write the live pins
    if (any_acc && (PADDR_I == `EIT_OFS_SNAP)) begin
      snap_d = PWRITE_I ? {PORTB_I, PORTA_I} : prdata_q[15:0];
    end
    // set wins over a software clear in the same cycle
    if (ext_edge[0]) begin
      main_d[`EIT_MAIN_E0F] = 1'b1;
    end
    if (ext_edge[1]) begin
      ctl3_d[`EIT_CTL3_E1F] = 1'b1;
    end
    if (ext_edge[2]) begin
      ctl3_d[`EIT_CTL3_E2F] = 1'b1;
    end
    if (tmr_ovf) begin
      main_d[`EIT_MAIN_TOF] = 1'b1;
    end
    if (chg_mis) begin
      main_d[`EIT_MAIN_CHF] = 1'b1;
    end
  end

  // register update of the software-visible state
  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      main_q <= `EIT_RST_MAIN;
      ctl2_q <= `EIT_RST_CTL2;
      ctl3_q <= `EIT_RST_CTL3;
      rcp_q <= `EIT_RST_RCP;
      maska_q <= `EIT_RST_MASK;
      maskb_q <= `EIT_RST_MASK;
      tmode_q <= `EIT_RST_TMODE;
      snap_q <= 16'h0000;
    end else begin
      main_q <= main_d;
      ctl2_q <= ctl2_d;
      ctl3_q <= ctl3_d;
      rcp_q <= rcp_d;
      maska_q <= maska_d;
      maskb_q <= maskb_d;
      tmode_q <= tmode_d;
      snap_q <= snap_d;
    end
  end

  // ---------------------------------------------------------------
  // apb read path: data built in setup so it leaves a flip-flop
  // ---------------------------------------------------------------
  always_comb begin
    prdata_d = prdata_q;
    slverr_d = slverr_q;
    mapped = 1'b1;
    if (PSEL_I && !PENABLE_I) begin
      prdata_d = 32'h0000_0000;
      case (PADDR_I)
        `EIT_OFS_MAIN: prdata_d[7:0] = main_q;
        `EIT_OFS_CTL2: prdata_d[7:0] = ctl2_q;
        `EIT_OFS_CTL3: prdata_d[7:0] = ctl3_q;
        `EIT_OFS_RCP: prdata_d[7:0] = rcp_q;
        `EIT_OFS_MASKA: prdata_d[7:0] = maska_q;
        `EIT_OFS_MASKB: prdata_d[7:0] = maskb_q;
        `EIT_OFS_SNAP: prdata_d[15:0] = {PORTB_I, PORTA_I};
        `EIT_OFS_TMODE: prdata_d[7:0] = tmode_q;
        default: mapped = 1'b0;
      endcase
      slverr_d = ~mapped;
    end
  end

  // read data and error registers
  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      prdata_q <= 32'h0000_0000;
      slverr_q <= 1'b0;
    end else begin
      prdata_q <= prdata_d;
      slverr_q <= slverr_d;
    end
  end

  assign PRDATA_O = prdata_q;
  assign PREADY_O = 1'b1; // no wait states
  assign PSLVERR_O = PSEL_I & PENABLE_I & slverr_q;

  // ---------------------------------------------------------------
  // request levels, wake and branch
  // ---------------------------------------------------------------
  assign ext_pend = ext_flag & ext_en;
  assign tmr_pend = main_q[`EIT_MAIN_TOF] & main_q[`EIT_MAIN_TOE];
  assign chg_pend = main_q[`EIT_MAIN_CHF] & main_q[`EIT_MAIN_CHE];
  assign sleep_hold = SLEEP_I & sleep_prev_q;

  // single-level mode sends every source to the high line
  always_comb begin
    lvl1 = (ctl3_q[`EIT_CTL3_E1P] || !ple) ? eit_pkg::EIT_LVL_HIGH : eit_pkg::EIT_LVL_LOW;
    lvl2 = (ctl3_q[`EIT_CTL3_E2P] || !ple) ? eit_pkg::EIT_LVL_HIGH : eit_pkg::EIT_LVL_LOW;
    lvlt = (ctl2_q[`EIT_CTL2_TOP] || !ple) ? eit_pkg::EIT_LVL_HIGH : eit_pkg::EIT_LVL_LOW;
    lvlc = (ctl2_q[`EIT_CTL2_CHP] || !ple) ? eit_pkg::EIT_LVL_HIGH : eit_pkg::EIT_LVL_LOW;
    irq_high_d = ext_pend[0]
      | (ext_pend[1] & (lvl1 == eit_pkg::EIT_LVL_HIGH))
      | (ext_pend[2] & (lvl2 == eit_pkg::EIT_LVL_HIGH))
      | (tmr_pend & (lvlt == eit_pkg::EIT_LVL_HIGH))
      | (chg_pend & (lvlc == eit_pkg::EIT_LVL_HIGH));
    irq_low_d = (ext_pend[1] & (lvl1 == eit_pkg::EIT_LVL_LOW))
      | (ext_pend[2] & (lvl2 == eit_pkg::EIT_LVL_LOW))
      | (tmr_pend & (lvlt == eit_pkg::EIT_LVL_LOW))
      | (chg_pend & (lvlc == eit_pkg::EIT_LVL_LOW));
    // enables count only as they stood when low power was entered
    en_sleep_d = (SLEEP_I && !sleep_prev_q) ? ext_en : en_sleep_q;
    wake_d = sleep_hold & (|(ext_flag & en_sleep_q));
    vector_d = wake_d & main_q[`EIT_MAIN_GEN];
  end

  // history and output registers
  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      ext_prev_q <= 3'h0;
      tmr_prev_q <= 16'h0000;
      sleep_prev_q <= 1'b0;
      en_sleep_q <= 3'h0;
      irq_high_q <= 1'b0;
      irq_low_q <= 1'b0;
      wake_q <= 1'b0;
      vector_q <= 1'b0;
    end else begin
      ext_prev_q <= EXT_IRQ_I;
      tmr_prev_q <= TIMER_COUNT_I;
      sleep_prev_q <= SLEEP_I;
      en_sleep_q <= en_sleep_d;
      irq_high_q <= irq_high_d;
      irq_low_q <= irq_low_d;
      wake_q <= wake_d;
      vector_q <= vector_d;
    end
  end

  assign IRQ_HIGH_O = irq_high_q;
  assign IRQ_LOW_O = irq_low_q;
  assign WAKE_O = wake_q;
  assign VECTOR_O = vector_q;
  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  property p_rise_sets_flag;
    @(posedge CLK_I) disable iff (!RESET_N_I)
      (ext_pol[1] && $rose(EXT_IRQ_I[1])) |=> ctl3_q[`EIT_CTL3_E1F];
  endproperty
  a_rise_sets_flag: assert property (p_rise_sets_flag) else $error("rising edge lost");
  property p_fall_sets_flag;
    @(posedge CLK_I) disable iff (!RESET_N_I)
      (!ext_pol[0] && $fell(EXT_IRQ_I[0])) |=> main_q[`EIT_MAIN_E0F];
  endproperty
  a_fall_sets_flag: assert property (p_fall_sets_flag) else $error("falling edge lost");
  property p_no_pend_no_irq;
    @(posedge CLK_I) disable iff (!RESET_N_I)
      (ext_pend == 3'h0 && !tmr_pend && !chg_pend) |=> (!IRQ_HIGH_O && !IRQ_LOW_O);
  endproperty
  a_no_pend_no_irq: assert property (p_no_pend_no_irq) else $error("request without pending source");
  property p_ext0_high;
    @(posedge CLK_I) disable iff (!RESET_N_I)
      ext_pend[0] |=> IRQ_HIGH_O;
  endproperty
  a_ext0_high: assert property (p_ext0_high) else $error("ext zero not high");
  property p_ext1_level;
    @(posedge CLK_I) disable iff (!RESET_N_I)
      (ple && ext_pend[1] && !ctl3_q[`EIT_CTL3_E1P]) |=> IRQ_LOW_O;
  endproperty
  a_ext1_level: assert property (p_ext1_level) else $error("ext one level wrong");
  property p_single_level;
    @(posedge CLK_I) disable iff (!RESET_N_I)
      !ple |=> !IRQ_LOW_O;
  endproperty
  a_single_level: assert property (p_single_level) else $error("low request in single mode");
  property p_tmr8_ovf;
    @(posedge CLK_I) disable iff (!RESET_N_I)
      (!tmode_q[`EIT_TMODE_16] && $past(TIMER_COUNT_I[7:0]) == 8'hFF && TIMER_COUNT_I[7:0] == 8'h00)
      |=> main_q[`EIT_MAIN_TOF];
  endproperty
  a_tmr8_ovf: assert property (p_tmr8_ovf) else $error("8-bit overflow lost");
  property p_tmr_high;
    @(posedge CLK_I) disable iff (!RESET_N_I)
      (tmr_pend && ctl2_q[`EIT_CTL2_TOP]) |=> IRQ_HIGH_O;
  endproperty
  a_tmr_high: assert property (p_tmr_high) else $error("timer request missing");
  property p_change_flag;
    @(posedge CLK_I) disable iff (!RESET_N_I)
      ((|((PORTA_I ^ snap_q[7:0]) & maska_q)) || (|((PORTB_I ^ snap_q[15:8]) & maskb_q)))
      |=> main_q[`EIT_MAIN_CHF];
  endproperty
  a_change_flag: assert property (p_change_flag) else $error("port change lost");
  property p_wake;
    @(posedge CLK_I) disable iff (!RESET_N_I)
      (sleep_hold && (ext_flag & en_sleep_q) != 3'h0) |=> WAKE_O ##0 (VECTOR_O == $past(main_q[`EIT_MAIN_GEN]));
  endproperty
  a_wake: assert property (p_wake) else $error("wake or branch wrong");
endmodule

// *** dv/eit_far_model.sv ***
// far-side model: external irq pins, timer count, port pins and core sleep state
`timescale 1ns/1ns
module eit_far_model (
  input wire logic clk_i,
  output logic [2:0] ext_o,
  output logic [15:0] tmr_o,
  output logic [7:0] pa_o,
  output logic [7:0] pb_o,
  output logic sleep_o
);
  // ---------------------------------------------------------------
  // levels start low so that release of reset shows no edge
  // ---------------------------------------------------------------
  initial begin
    ext_o = 3'h0;
    tmr_o = 16'h0000;
    pa_o = 8'h00;
    pb_o = 8'h00;
    sleep_o = 1'b0;
  end
  // ---------------------------------------------------------------
  // all levels move together just after an edge
  // ---------------------------------------------------------------
  // three edges pass so the flag and the request have both landed
  task put(input logic [2:0] e, input logic [15:0] t, input logic [7:0] a, input logic [7:0] b, input logic s);
    @(posedge clk_i);
    ext_o <= e;
    tmr_o <= t;
    pa_o <= a;
    pb_o <= b;
    sleep_o <= s;
    repeat (3) @(posedge clk_i);
    #1;
  endtask
endmodule

// *** dv/testbench.sv ***
// self-checking bench for the irq source block
`timescale 1ns/1ns
`include "eit_defs.svh"
module testbench;
  logic clk = 1'b0; // 100 MHz system clock
  logic rst_n = 1'b0; // active low reset
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata, rdat;
  logic pready, pslverr, rerr;
  logic [2:0] ext;
  logic [15:0] tmr;
  logic [7:0] pa, pb;
  logic slp, irqh, irql, wake, vec;
  int err_count = 0; // mismatches seen
  int cmp_count = 0; // comparisons made
  int cyc = 0; // cycle counter for the hang guard
  always #5 clk = ~clk;
  eit_irq_sources i_dut (.CLK_I(clk), .RESET_N_I(rst_n), .PSEL_I(psel), .PENABLE_I(penable),
    .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
    .PSLVERR_O(pslverr), .EXT_IRQ_I(ext), .TIMER_COUNT_I(tmr), .PORTA_I(pa), .PORTB_I(pb),
    .SLEEP_I(slp), .IRQ_HIGH_O(irqh), .IRQ_LOW_O(irql), .WAKE_O(wake), .VECTOR_O(vec));
  eit_far_model i_far (.clk_i(clk), .ext_o(ext), .tmr_o(tmr), .pa_o(pa), .pb_o(pb), .sleep_o(slp));
  // ---------------------------------------------------------------
  // report and checking helpers
  // ---------------------------------------------------------------
  task test_done;
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // apb transfer; waits on pready for as long as it takes, only the hang guard ends a stuck wait
  task apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) begin
      @(posedge clk);
    end
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
  endtask
  task wr(input logic [11:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
  endtask
  // read expecting no error
  task rd(input logic [11:0] a, input logic [15:0] e);
    apb(1'b0, a, 8'h00);
    chk({rerr, rdat[30:0]}, {16'h0000, e});
  endtask
  // outputs in order high, low, wake, vector
  task sig(input logic [3:0] e);
    chk({28'h0, irqh, irql, wake, vec}, {28'h0, e});
  endtask
  // ---------------------------------------------------------------
  // hang guard: the sequence needs well under a thousand cycles
  // ---------------------------------------------------------------
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      err_count++;
      test_done;
    end
  end
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    rd(`EIT_OFS_MAIN, 16'h00);
    rd(`EIT_OFS_CTL2, 16'h75);
    rd(`EIT_OFS_CTL3, 16'hC0);
    rd(`EIT_OFS_TMODE, 16'h00);
    apb(1'b0, 12'h020, 8'h00);
    chk({rerr, rdat[30:0]}, 32'h80000000); // unmapped word answers with an error
    wr(`EIT_OFS_CTL2, 8'hFF);
    rd(`EIT_OFS_CTL2, 16'h75); // read-only bits keep their value
    wr(`EIT_OFS_RCP, 8'hFF);
    rd(`EIT_OFS_RCP, 16'h80);
    // ext one: rising edge with polarity set, enable still off
    i_far.put(3'b010, 16'h0000, 8'h00, 8'h00, 1'b0);
    rd(`EIT_OFS_CTL3, 16'hC1);
    sig(4'b0000);
    wr(`EIT_OFS_CTL3, 8'hC9);
    sig(4'b1000);
    wr(`EIT_OFS_CTL3, 8'h89);
    sig(4'b0100);
    wr(`EIT_OFS_RCP, 8'h00);
    sig(4'b1000);
    wr(`EIT_OFS_RCP, 8'h80);
    wr(`EIT_OFS_CTL3, 8'h80);
    // falling polarity: fall sets the flag, rise does not
    wr(`EIT_OFS_CTL2, 8'h55);
    i_far.put(3'b000, 16'h0000, 8'h00, 8'h00, 1'b0);
    rd(`EIT_OFS_CTL3, 16'h81);
    wr(`EIT_OFS_CTL3, 8'h80);
    i_far.put(3'b010, 16'h0000, 8'h00, 8'h00, 1'b0);
    rd(`EIT_OFS_CTL3, 16'h80);
    // ext zero has no priority bit and lands high
    i_far.put(3'b011, 16'h0000, 8'h00, 8'h00, 1'b0);
    rd(`EIT_OFS_MAIN, 16'h02);
    wr(`EIT_OFS_MAIN, 8'h12);
    sig(4'b1000);
    wr(`EIT_OFS_MAIN, 8'h00);
    // timer roll-over in 8-bit then 16-bit mode
    i_far.put(3'b011, 16'h00FF, 8'h00, 8'h00, 1'b0);
    i_far.put(3'b011, 16'h0100, 8'h00, 8'h00, 1'b0);
    rd(`EIT_OFS_MAIN, 16'h04);
    wr(`EIT_OFS_MAIN, 8'h00);
    wr(`EIT_OFS_TMODE, 8'h01);
    i_far.put(3'b011, 16'h01FF, 8'h00, 8'h00, 1'b0);
    i_far.put(3'b011, 16'h0200, 8'h00, 8'h00, 1'b0);
    rd(`EIT_OFS_MAIN, 16'h00);
    i_far.put(3'b011, 16'hFFFF, 8'h00, 8'h00, 1'b0);
    i_far.put(3'b011, 16'h0000, 8'h00, 8'h00, 1'b0);
    rd(`EIT_OFS_MAIN, 16'h04);
    sig(4'b0000);
    wr(`EIT_OFS_MAIN, 8'h24);
    sig(4'b1000);
    wr(`EIT_OFS_CTL2, 8'h51);
    sig(4'b0100);
    wr(`EIT_OFS_MAIN, 8'h00);
    wr(`EIT_OFS_CTL2, 8'h55);
    // port change against the last snapshot, masked pins only
    wr(`EIT_OFS_MASKA, 8'h01);
    rd(`EIT_OFS_SNAP, 16'h0000);
    i_far.put(3'b011, 16'h0000, 8'h02, 8'h00, 1'b0);
    rd(`EIT_OFS_MAIN, 16'h00);
    i_far.put(3'b011, 16'h0000, 8'h03, 8'h00, 1'b0);
    rd(`EIT_OFS_MAIN, 16'h01);
    rd(`EIT_OFS_SNAP, 16'h0003);
    wr(`EIT_OFS_MAIN, 8'h00);
    rd(`EIT_OFS_MAIN, 16'h00);
    wr(`EIT_OFS_MASKB, 8'h80);
    i_far.put(3'b011, 16'h0000, 8'h03, 8'h80, 1'b0);
    rd(`EIT_OFS_MAIN, 16'h01);
    sig(4'b0000);
    wr(`EIT_OFS_MAIN, 8'h09);
    sig(4'b1000);
    wr(`EIT_OFS_CTL2, 8'h54);
    sig(4'b0100);
    rd(`EIT_OFS_SNAP, 16'h8003);
    wr(`EIT_OFS_MAIN, 8'h00);
    // wake from sleep, with and without the global enable
    i_far.put(3'b010, 16'h0000, 8'h03, 8'h80, 1'b0);
    wr(`EIT_OFS_MAIN, 8'h90);
    i_far.put(3'b010, 16'h0000, 8'h03, 8'h80, 1'b1);
    i_far.put(3'b011, 16'h0000, 8'h03, 8'h80, 1'b1);
    sig(4'b1011);
    i_far.put(3'b010, 16'h0000, 8'h03, 8'h80, 1'b0);
    wr(`EIT_OFS_MAIN, 8'h10);
    i_far.put(3'b010, 16'h0000, 8'h03, 8'h80, 1'b1);
    i_far.put(3'b011, 16'h0000, 8'h03, 8'h80, 1'b1);
    sig(4'b1010);
    i_far.put(3'b010, 16'h0000, 8'h03, 8'h80, 1'b0);
    wr(`EIT_OFS_MAIN, 8'h00);
    i_far.put(3'b010, 16'h0000, 8'h03, 8'h80, 1'b1);
    wr(`EIT_OFS_MAIN, 8'h10);
    i_far.put(3'b011, 16'h0000, 8'h03, 8'h80, 1'b1);
    sig(4'b1000);
    // ext zero with falling polarity, then ext two at both levels
    wr(`EIT_OFS_MAIN, 8'h00);
    wr(`EIT_OFS_CTL2, 8'h15);
    i_far.put(3'b010, 16'h0000, 8'h03, 8'h80, 1'b0);
    rd(`EIT_OFS_MAIN, 16'h02);
    i_far.put(3'b110, 16'h0000, 8'h03, 8'h80, 1'b0);
    rd(`EIT_OFS_CTL3, 16'h82);
    wr(`EIT_OFS_CTL3, 8'h92);
    sig(4'b1000);
    wr(`EIT_OFS_CTL3, 8'h12);
    sig(4'b0100);
    test_done;
  end
endmodule
